// ### hw/icc_capture.sv
// Input capture channel with a four-entry capture buffer behind an AXI4-Lite slave.
//
// Function
// [RULE1] With the idle halt bit set the channel does nothing while the CPU idles, otherwise it keeps capturing.
// [RULE2] Each capture stores the timer two count when the timebase bit is 1 and the timer three count when 0.
// [RULE3] The captures-per-interrupt field raises an interrupt on every first, second, third or fourth capture.
// [RULE4] A read-only overrun flag is set on a capture overflow, cleared only by hardware, and ignores writes.
// [RULE5] A read-only buffer flag reads 1 while any captured value is unread and 0 when the buffer is empty.
// [RULE6] Mode 111 only raises an interrupt on a rising edge during Sleep or Idle and ignores the other bits.
// [RULE7] Mode 000 switches the channel off and the unused mode 110 leaves it disabled as well.
// [RULE8] Mode 101 captures once for every sixteenth rising edge on the pin.
// [RULE9] Mode 100 captures once for every fourth rising edge on the pin.
// [RULE10] Mode 011 captures on every rising edge on the pin.
// [RULE11] Mode 010 captures on every falling edge on the pin.
// [RULE12] Mode 001 captures on both edges and interrupts on every capture, whatever the interrupt field says.
// [RULE13] Unimplemented control bits read as zero and writes to them are dropped.
// [RULE14] The buffer holds four values in arrival order and each read of it removes the oldest one.
// [RULE15] A capture into a full buffer is discarded and flags overflow, which clears when the channel is off.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module icc_capture
  import icc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Capture pin and timebases
  input wire logic cap_pin,
  input wire icc_timers_t timers,
  // Power state of the CPU
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);

  icc_state_t st_r;
  icc_state_t st_nxt;
  logic rise;
  logic fall;
  logic halted;
  logic disabled;
  logic edge_hit;
  logic cap_evt;
  logic wake_evt;
  logic int_evt;
  logic full;
  logic push;
  logic ovf_evt;
  logic pop;
  logic [1:0] clr;
  logic [15:0] ctrl_word;
  logic [2:0] ar_idx;
  logic ar_hit;

  // ****************************************
  // Register views
  // ****************************************
  // [RULE13] zero unimplemented bits
  always_comb begin
    ctrl_word = CTRL_RESET;
    ctrl_word[BIT_IDLE_HALT] = st_r.idle_halt;
    ctrl_word[BIT_TSEL] = st_r.tsel;
    ctrl_word[POS_CPI +: 2] = st_r.cpi;
    ctrl_word[BIT_OVF] = st_r.ovf;
    // [RULE5] buffer flag from count
    ctrl_word[BIT_BNE] = (st_r.cnt != 3'h0);
    ctrl_word[POS_MODE +: 3] = st_r.mode;
  end

  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign irq = |(st_r.sts & st_r.en);
  assign ar_idx = s_axi_araddr[4:2];
  assign ar_hit = (s_axi_araddr[ADDR_W-1:5] == '0) && (s_axi_araddr[1:0] == 2'h0) && (ar_idx <= IDX_CLR);

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    pop = 1'b0;
    clr = 2'h0;
    // The first stage feeds only the second; edges come from stages two and three agreeing.
    st_nxt.sync = {st_r.sync[1:0], cap_pin};
    rise = st_r.sync[1] && st_r.sync[2] && !st_r.lvl;
    fall = !st_r.sync[1] && !st_r.sync[2] && st_r.lvl;
    if (st_r.sync[1] == st_r.sync[2]) begin
      st_nxt.lvl = st_r.sync[1];
    end
    // [RULE1] halt in idle when asked
    halted = cpu_sleep || (st_r.idle_halt && cpu_idle);
    // [RULE7] off and unused modes
    disabled = (st_r.mode == MODE_OFF) || (st_r.mode == MODE_UNUSED);
    case (st_r.mode)
      // [RULE12] both edges
      MODE_BOTH: edge_hit = rise || fall;
      // [RULE11] falling edges
      MODE_FALL: edge_hit = fall;
      // [RULE10] rising edges
      MODE_RISE: edge_hit = rise;
      // [RULE9] every fourth rising edge
      MODE_DIV4: edge_hit = rise && (st_r.pre == PRE4_LAST);
      // [RULE8] every sixteenth rising edge
      MODE_DIV16: edge_hit = rise && (st_r.pre == PRE16_LAST);
      default: edge_hit = 1'b0;
    endcase
    cap_evt = edge_hit && !halted;
    // [RULE6] wake-only interrupt pin
    wake_evt = (st_r.mode == MODE_WAKE) && rise && (cpu_idle || cpu_sleep);
    if ((st_r.mode == MODE_DIV4) || (st_r.mode == MODE_DIV16)) begin
      if (rise && !halted) begin
        st_nxt.pre = cap_evt ? 4'h0 : 4'(st_r.pre + 4'h1);
      end
    end else begin
      st_nxt.pre = 4'h0;
    end
    // [RULE3] captures per interrupt
    int_evt = 1'b0;
    if (disabled || (st_r.mode == MODE_WAKE)) begin
      st_nxt.icnt = 2'h0;
    end else if (cap_evt && (st_r.mode == MODE_BOTH)) begin
      int_evt = 1'b1;
    end else if (cap_evt) begin
      if (st_r.icnt == st_r.cpi) begin
        int_evt = 1'b1;
        st_nxt.icnt = 2'h0;
      end else begin
        st_nxt.icnt = 2'(st_r.icnt + 2'h1);
      end
    end
    int_evt = int_evt || wake_evt;
    // [RULE15] discard into a full buffer
    full = (st_r.cnt == FIFO_FULL_CNT);
    push = cap_evt && !full;
    ovf_evt = cap_evt && full;

    // Read channel; a read of the buffer register pops the oldest value.
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = ar_hit ? RESP_OKAY : RESP_SLVERR;
      st_nxt.rdata = 32'h0000_0000;
      if (ar_hit) begin
        case (ar_idx)
          IDX_CTRL: st_nxt.rdata = {16'h0000, ctrl_word};
          IDX_BUF: begin
            st_nxt.rdata = {16'h0000, st_r.fifo[st_r.rp]};
            pop = (st_r.cnt != 3'h0);
          end
          IDX_STS: st_nxt.rdata = {30'h0000_0000, st_r.sts};
          IDX_EN: st_nxt.rdata = {30'h0000_0000, st_r.en};
          default: st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Write channels; address and data are taken in either order, the write lands once both are held.
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata[15:0];
      st_nxt.wstrb = s_axi_wstrb[1:0];
    end
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if ((st_r.awaddr[ADDR_W-1:5] != '0) || (st_r.awaddr[1:0] != 2'h0) || (st_r.awaddr[4:2] > IDX_CLR)) begin
        st_nxt.bresp = RESP_SLVERR;
      end else begin
        case (st_r.awaddr[4:2])
          // [RULE13] only implemented bits are written; the flags are read-only
          IDX_CTRL: begin
            if (st_r.wstrb[1]) begin
              st_nxt.idle_halt = st_r.wdata[BIT_IDLE_HALT];
            end
            if (st_r.wstrb[0]) begin
              st_nxt.tsel = st_r.wdata[BIT_TSEL];
              st_nxt.cpi = st_r.wdata[POS_CPI +: 2];
              st_nxt.mode = st_r.wdata[POS_MODE +: 3];
            end
          end
          IDX_EN: begin
            if (st_r.wstrb[0]) begin
              st_nxt.en = st_r.wdata[1:0];
            end
          end
          IDX_CLR: begin
            if (st_r.wstrb[0]) begin
              clr = st_r.wdata[1:0];
            end
          end
          default: st_nxt.bresp = RESP_OKAY;
        endcase
      end
    end

    // A new event wins over a clear in the same cycle.
    st_nxt.sts = (st_r.sts & ~clr) | {ovf_evt, int_evt};

    // [RULE14] four-entry first-in first-out buffer
    if (disabled) begin
      st_nxt.wp = 2'h0;
      st_nxt.rp = 2'h0;
      st_nxt.cnt = 3'h0;
    end else begin
      if (push) begin
        // [RULE2] timebase choice
        st_nxt.fifo[st_r.wp] = st_r.tsel ? timers.two : timers.three;
        st_nxt.wp = 2'(st_r.wp + 2'h1);
      end
      if (pop) begin
        st_nxt.rp = 2'(st_r.rp + 2'h1);
      end
      st_nxt.cnt = 3'(st_r.cnt + {2'h0, push} - {2'h0, pop});
    end
    // [RULE4] overflow set by hardware, cleared only when off
    if (disabled) begin
      st_nxt.ovf = 1'b0;
    end else if (ovf_evt) begin
      st_nxt.ovf = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence s_full_capture;
    cap_evt && full;
  endsequence

  property p_idle_halt;
    st_r.idle_halt && cpu_idle && !disabled |-> !cap_evt;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("capture while halted in idle"); // [RULE1]

  property p_timebase;
    push && st_r.tsel |=> st_r.fifo[$past(st_r.wp)] == $past(timers.two);
  endproperty
  a_timebase: assert property (p_timebase) else $error("wrong timer stored"); // [RULE2]

  property p_per_int;
    cap_evt && (st_r.mode != MODE_BOTH) |-> int_evt == (st_r.icnt == st_r.cpi);
  endproperty
  a_per_int: assert property (p_per_int) else $error("interrupt spacing wrong"); // [RULE3]

  property p_overrun;
    s_full_capture ##1 !disabled |-> st_r.ovf && st_r.sts[1];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // [RULE4]

  property p_empty_after_pop;
    pop && (st_r.cnt == 3'h1) && !push && !disabled |=> !ctrl_word[BIT_BNE];
  endproperty
  a_empty_after_pop: assert property (p_empty_after_pop) else $error("buffer flag stuck"); // [RULE5]

  property p_wake;
    (st_r.mode == MODE_WAKE) |-> !cap_evt && (int_evt == (rise && (cpu_idle || cpu_sleep)));
  endproperty
  a_wake: assert property (p_wake) else $error("wake mode misbehaves"); // [RULE6]

  property p_off;
    disabled |=> (st_r.cnt == 3'h0) && !st_r.ovf;
  endproperty
  a_off: assert property (p_off) else $error("disabled channel holds data"); // [RULE7]

  property p_div16;
    (st_r.mode == MODE_DIV16) && rise && !halted |-> cap_evt == (st_r.pre == 4'hF);
  endproperty
  a_div16: assert property (p_div16) else $error("divide by sixteen wrong"); // [RULE8]

  property p_div4;
    (st_r.mode == MODE_DIV4) && rise && !halted && (st_r.pre == 4'h3) |-> cap_evt ##1 (st_r.pre == 4'h0);
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four wrong"); // [RULE9]

  property p_rise;
    (st_r.mode == MODE_RISE) && !halted |-> cap_evt == rise;
  endproperty
  a_rise: assert property (p_rise) else $error("rising capture wrong"); // [RULE10]

  property p_fall;
    (st_r.mode == MODE_FALL) && !halted |-> cap_evt == fall;
  endproperty
  a_fall: assert property (p_fall) else $error("falling capture wrong"); // [RULE11]

  property p_both;
    (st_r.mode == MODE_BOTH) && cap_evt |-> int_evt;
  endproperty
  a_both: assert property (p_both) else $error("both-edge interrupt missing"); // [RULE12]

  property p_unimpl;
    (ctrl_word[15:14] == 2'h0) && (ctrl_word[12:8] == 5'h00);
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set"); // [RULE13]

  property p_fifo_order;
    push && (st_r.cnt == 3'h0) && !pop ##1 pop |-> st_nxt.rdata[15:0] == $past(st_nxt.fifo[st_r.wp]);
  endproperty
  a_fifo_order: assert property (p_fifo_order) else $error("oldest value not returned"); // [RULE14]

  property p_discard;
    s_full_capture and !pop |=> st_r.wp == $past(st_r.wp);
  endproperty
  a_discard: assert property (p_discard) else $error("full buffer overwritten"); // [RULE15]

endmodule : icc_capture

// ### pkg/icc_pkg.sv
// Package with the register map, encodings and state layout of the input capture channel.
package icc_pkg;

  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_BUF = 3'h1;
  localparam logic [2:0] IDX_STS = 3'h2;
  localparam logic [2:0] IDX_EN = 3'h3;
  localparam logic [2:0] IDX_CLR = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int BIT_IDLE_HALT = 13;
  localparam int BIT_TSEL = 7;
  localparam int POS_CPI = 5;
  localparam int BIT_OVF = 4;
  localparam int BIT_BNE = 3;
  localparam int POS_MODE = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ****************************************
  // Mode encodings and counts
  // ****************************************
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_BOTH = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_DIV4 = 3'h4;
  localparam logic [2:0] MODE_DIV16 = 3'h5;
  localparam logic [2:0] MODE_UNUSED = 3'h6;
  localparam logic [2:0] MODE_WAKE = 3'h7;
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_FULL_CNT = 3'h4;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [15:0] two;
    logic [15:0] three;
  } icc_timers_t;

  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic idle_halt;
    logic tsel;
    logic [1:0] cpi;
    logic [2:0] mode;
    logic [3:0] pre;
    logic [1:0] icnt;
    logic ovf;
    logic [FIFO_DEPTH-1:0][15:0] fifo;
    logic [1:0] wp;
    logic [1:0] rp;
    logic [2:0] cnt;
    logic [1:0] sts;
    logic [1:0] en;
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } icc_state_t;

endpackage : icc_pkg

// ### dv/icc_pin_src.sv
// Model of the external digital signal on the capture pin.
`timescale 1ns/1ps
module icc_pin_src (
  // Clock and pin
  input wire logic clock,
  output logic pin
);
  initial begin
    pin = 1'b0;
  end

  // Each level is held three cycles so the synchroniser always sees it settle.
  task automatic pulse(input int n);
    repeat (n) begin
      pin <= 1'b1;
      repeat (3) @(posedge clock);
      pin <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask : pulse

  task automatic drive(input logic v);
    pin <= v;
    repeat (8) @(posedge clock);
  endtask : drive
endmodule : icc_pin_src

// ### dv/icc_capture_tb.sv
// Self-checking testbench of the input capture channel.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module icc_capture_tb
  import icc_pkg::*;
;
  logic clock, rst_b, cap_pin, cpu_idle, cpu_sleep, irq;
  icc_timers_t timers;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int fails, cmp_count, cyc, n;

  icc_capture icc_capture_inst (.clock(clock), .rst_b(rst_b), .cap_pin(cap_pin), .timers(timers),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  icc_pin_src icc_pin_src_inst (.clock(clock), .pin(cap_pin));

  // ****************************************
  // Bus tasks
  // ****************************************
  // Readies are looked at on the falling edge, so the handshake edge is the next rising one.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd, ta, tw, got;
    ad = 0;
    wd = 0;
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clock);
      if (ta) begin awvalid <= 1'b0; ad = 1; end
      if (tw) begin wvalid <= 1'b0; wd = 1; end
    end
    bready <= 1'b1;
    do begin
      @(negedge clock);
      got = bvalid;
      rs = bresp;
      @(posedge clock);
    end while (!got);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bit got;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge clock);
      got = arready;
      @(posedge clock);
    end while (!got);
    arvalid <= 1'b0;
    do begin
      @(negedge clock);
      got = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge clock);
    end while (!got);
    // Ready stays up between reads so that back-to-back calls never assign it twice in one step.
  endtask : rd

  task automatic edges(input int k);
    if (k > 0) icc_pin_src_inst.pulse(k);
    repeat (6) @(posedge clock);
  endtask : edges

  task automatic drain(output int k);
    k = 0;
    repeat (6) begin
      rd(8'h00);
      `CHK("bne known", 1'b0, $isunknown(rv[BIT_BNE]))
      if (rv[BIT_BNE]) begin rd(8'h04); k++; end
    end
  endtask : drain

  task automatic restart(input logic [31:0] c);
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h3);
    wr(8'h00, c);
  endtask : restart

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd(8'h00); `CHK("ctrl reset", 32'h0, rv)
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00); `CHK("ctrl mask", 32'h0000_20E7, rv)
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h1); `CHK("unmapped wr", RESP_SLVERR, rs)
    rd(8'h14); `CHK("unmapped rd", RESP_SLVERR, rs)
    $display("test regs done");
  endtask : t_regs

  task automatic t_rise;
    wr(8'h0C, 32'h3);
    timers <= '{two: 16'hAAAA, three: 16'h5555};
    restart(32'h83);
    icc_pin_src_inst.drive(1'b1);
    rd(8'h00); `CHK("bne after rise", 1'b1, rv[BIT_BNE])
    `CHK("irq set", 1'b1, irq)
    wr(8'h0C, 32'h0); `CHK("irq masked", 1'b0, irq)
    wr(8'h0C, 32'h1); `CHK("irq unmasked", 1'b1, irq)
    rd(8'h04); `CHK("timer two", 32'h0000_AAAA, rv)
    rd(8'h00); `CHK("bne empty", 1'b0, rv[BIT_BNE])
    icc_pin_src_inst.drive(1'b0);
    drain(n); `CHK("no capture on fall", 0, n)
    wr(8'h10, 32'h3); `CHK("irq cleared", 1'b0, irq)
    wr(8'h00, 32'h3);
    edges(1);
    rd(8'h04); `CHK("timer three", 32'h0000_5555, rv)
    $display("test rise done");
  endtask : t_rise

  task automatic t_ovf;
    restart(32'h3);
    for (int i = 0; i < 5; i++) begin
      timers.three <= 16'h0100 + 16'(i);
      edges(1);
    end
    wr(8'h00, 32'h3);
    rd(8'h00); `CHK("ovf and bne", 2'b11, rv[4:3])
    rd(8'h08); `CHK("ovf status", 1'b1, rv[1])
    for (int i = 0; i < 4; i++) begin
      rd(8'h04); `CHK("fifo order", 32'h0100 + i, rv)
    end
    wr(8'h00, 32'h0);
    rd(8'h00); `CHK("ovf cleared", 32'h0, rv)
    $display("test overflow done");
  endtask : t_ovf

  task automatic t_modes;
    for (int c = 1; c < 4; c++) begin
      restart(32'h3 | (c << POS_CPI));
      edges(c);
      rd(8'h08); `CHK("cpi early", 1'b0, rv[0])
      edges(1);
      rd(8'h08); `CHK("cpi due", 1'b1, rv[0])
    end
    restart(32'h61);
    edges(1);
    rd(8'h08); `CHK("both edges irq", 1'b1, rv[0])
    drain(n); `CHK("both edges count", 2, n)
    restart(32'h2);
    icc_pin_src_inst.drive(1'b1);
    drain(n); `CHK("fall on rise", 0, n)
    icc_pin_src_inst.drive(1'b0);
    drain(n); `CHK("fall on fall", 1, n)
    for (int m = 4; m < 6; m++) begin
      restart(32'(m));
      edges(m == 4 ? 3 : 15);
      drain(n); `CHK("prescale early", 0, n)
      edges(1);
      drain(n); `CHK("prescale due", 1, n)
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_power;
    restart(32'h2003);
    cpu_idle <= 1'b1;
    edges(1);
    drain(n); `CHK("halt in idle", 0, n)
    wr(8'h00, 32'h3);
    edges(1);
    drain(n); `CHK("run in idle", 1, n)
    cpu_idle <= 1'b0;
    restart(32'h7);
    edges(1);
    rd(8'h08); `CHK("wake mode awake", 1'b0, rv[0])
    cpu_sleep <= 1'b1;
    edges(1);
    rd(8'h08); `CHK("wake mode asleep", 1'b1, rv[0])
    drain(n); `CHK("wake no capture", 0, n)
    cpu_sleep <= 1'b0;
    restart(32'h6);
    edges(1);
    rd(8'h08); `CHK("unused mode irq", 1'b0, rv[0])
    drain(n); `CHK("unused mode capture", 0, n)
    $display("test power done");
  endtask : t_power

  // ****************************************
  // Run control
  // ****************************************
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // The ceiling is dozens of times the expected run length.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    rst_b = 1'b0; cpu_idle = 1'b0; cpu_sleep = 1'b0; timers = '0; awaddr = '0; araddr = '0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    wdata = '0; wstrb = '0; fails = 0; cmp_count = 0; cyc = 0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_regs();
    t_rise();
    t_ovf();
    t_modes();
    t_power();
    conclude();
  end
endmodule : icc_capture_tb
